// ==== logic/cic_pkg.sv ====
// Purpose: constants for the core interrupt control register block
// Assumes: avalon-mm slave, byte addresses, 32-bit data, 8-bit registers
// Notes: bit positions follow the control register layout
package cic_pkg;
	// ------------------------------------------------------------
	// register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_IRQ_STATUS = 4'h4;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'h8;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam int REG_W = 8;
	// ------------------------------------------------------------
	// control register bit positions
	// ------------------------------------------------------------
	localparam int BIT_GLOBAL_EN = 7;
	localparam int BIT_PERIPH_EN = 6;
	localparam int BIT_T0IE = 5;
	localparam int BIT_EXIE = 4;
	localparam int BIT_PCIE = 3;
	localparam int BIT_T0IF = 2;
	localparam int BIT_EXIF = 1;
	localparam int BIT_PCIF = 0;
	localparam logic [6:0] CTRL_RESET_HI = 7'h00;
	// ------------------------------------------------------------
	// status and mask register bit positions
	// ------------------------------------------------------------
	localparam int EV_W = 3;
	localparam int EV_TMR = 0;
	localparam int EV_EXT = 1;
	localparam int EV_PORT = 2;
	localparam int PORT_W = 4;
endpackage : cic_pkg

// ==== logic/cic_core.sv ====
// Purpose: core interrupt control register with avalon-mm access
// Assumes: single clock, async active-high reset, pins are asynchronous
// Notes: flag bits set by hardware win over a software clear
//
// Local design decisions: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
module cic_core
	import cic_pkg::*;
#(
	parameter int NUM_PERIPH = 4,
	parameter logic PORT_FLAG_RESET = 1'b0
)
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [DATA_W-1:0] writedata,
	output logic [DATA_W-1:0] readdata,
	output logic waitrequest,
	input wire logic timer_zero_overflow,
	input wire logic external_irq_pin,
	input wire logic [PORT_W-1:0] upper_port_pins,
	input wire logic [NUM_PERIPH-1:0] periph_irq_pending,
	output logic core_irq_req,
	output logic irq
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [REG_W-1:0] ctrl;
		logic ack;
		logic [REG_W-1:0] rdata;
		logic rd_status;
		logic [EV_W-1:0] ist;
		logic [EV_W-1:0] imask;
		logic ext_s1;
		logic ext_s2;
		logic ext_d;
		logic [PORT_W-1:0] port_s1;
		logic [PORT_W-1:0] port_s2;
		logic [PORT_W-1:0] port_d;
	} cic_state_t;

	cic_state_t state_reg;
	cic_state_t state_next;
	logic ev_tmr;
	logic ev_ext;
	logic ev_port;
	logic req;
	logic take;
	logic periph_ok;
	logic src_ok;

	// ------------------------------------------------------------
	// events and request
	// ------------------------------------------------------------
	assign ev_tmr = timer_zero_overflow;
	assign ev_ext = state_reg.ext_s2 & ~state_reg.ext_d;
	assign ev_port = state_reg.port_s2 != state_reg.port_d;
	assign req = read | write;
	assign take = req & state_reg.ack;
	assign periph_ok = state_reg.ctrl[BIT_PERIPH_EN] & (|periph_irq_pending);
	assign src_ok = (state_reg.ctrl[BIT_T0IE] & state_reg.ctrl[BIT_T0IF])
		| (state_reg.ctrl[BIT_EXIE] & state_reg.ctrl[BIT_EXIF])
		| (state_reg.ctrl[BIT_PCIE] & state_reg.ctrl[BIT_PCIF]);
	assign core_irq_req = state_reg.ctrl[BIT_GLOBAL_EN] & (src_ok | periph_ok);
	assign irq = |(state_reg.ist & state_reg.imask);
	assign waitrequest = req & ~state_reg.ack;
	assign readdata = {{(DATA_W-REG_W){1'b0}}, state_reg.rdata};

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		logic [REG_W-1:0] rd;
		rd = '0;
		state_next = state_reg;
		state_next.ext_s1 = external_irq_pin;
		state_next.ext_s2 = state_reg.ext_s1;
		state_next.ext_d = state_reg.ext_s2;
		state_next.port_s1 = upper_port_pins;
		state_next.port_s2 = state_reg.port_s1;
		state_next.port_d = state_reg.port_s2;
		state_next.ack = req & ~state_reg.ack;
		unique case (address)
			ADDR_CTRL: rd = state_reg.ctrl;
			ADDR_IRQ_STATUS: rd = {{(REG_W-EV_W){1'b0}}, state_reg.ist};
			ADDR_IRQ_MASK: rd = {{(REG_W-EV_W){1'b0}}, state_reg.imask};
			default: rd = '0;
		endcase
		if (read & ~state_reg.ack)
		begin
			state_next.rdata = rd;
			state_next.rd_status = address == ADDR_IRQ_STATUS;
		end
		if (take & write)
		begin
			if (address == ADDR_CTRL)
				state_next.ctrl = writedata[REG_W-1:0];
			if (address == ADDR_IRQ_MASK)
				state_next.imask = writedata[EV_W-1:0];
		end
		if (take & read & state_reg.rd_status)
			state_next.ist = state_reg.ist & ~state_reg.rdata[EV_W-1:0];
		// set wins over any clear
		state_next.ctrl[BIT_T0IF] = state_next.ctrl[BIT_T0IF] | ev_tmr;
		state_next.ctrl[BIT_EXIF] = state_next.ctrl[BIT_EXIF] | ev_ext;
		state_next.ctrl[BIT_PCIF] = state_next.ctrl[BIT_PCIF] | ev_port;
		state_next.ist[EV_TMR] = state_next.ist[EV_TMR] | ev_tmr;
		state_next.ist[EV_EXT] = state_next.ist[EV_EXT] | ev_ext;
		state_next.ist[EV_PORT] = state_next.ist[EV_PORT] | ev_port;
	end

	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			state_reg <= '0;
			state_reg.ctrl <= {CTRL_RESET_HI, PORT_FLAG_RESET};
		end
		else
			state_reg <= state_next;
	end

	// ------------------------------------------------------------
	// checks: interrupt gating
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	periph_gate_a: assert property (
		(state_reg.ctrl[BIT_GLOBAL_EN] & state_reg.ctrl[BIT_PERIPH_EN] & (|periph_irq_pending)) |-> core_irq_req)
		else $error("enabled peripheral request not passed");
	periph_block_a: assert property (
		(~state_reg.ctrl[BIT_PERIPH_EN] & ~src_ok) |-> ~core_irq_req)
		else $error("peripheral request passed without group enable");
	ext_gate_a: assert property (
		(state_reg.ctrl[BIT_GLOBAL_EN] & state_reg.ctrl[BIT_EXIE] & state_reg.ctrl[BIT_EXIF]) |-> core_irq_req)
		else $error("external pin request not passed");
	port_gate_a: assert property (
		(state_reg.ctrl[BIT_GLOBAL_EN] & state_reg.ctrl[BIT_PCIE] & state_reg.ctrl[BIT_PCIF]) |-> core_irq_req)
		else $error("port change request not passed");
	all_masked_a: assert property (
		(~state_reg.ctrl[BIT_T0IE] & ~state_reg.ctrl[BIT_EXIE] & ~state_reg.ctrl[BIT_PCIE]
		& ~state_reg.ctrl[BIT_PERIPH_EN]) |-> ~core_irq_req)
		else $error("core request with every source masked");
	global_gate_a: assert property (
		~state_reg.ctrl[BIT_GLOBAL_EN] |-> ~core_irq_req)
		else $error("core request without global enable");
	irq_mask_a: assert property (
		(state_reg.imask == '0) |-> ~irq)
		else $error("interrupt line high with every status bit masked");

	// ------------------------------------------------------------
	// checks: flags and status
	// ------------------------------------------------------------
	reset_value_a: assert property (
		@(posedge sys_clk) disable iff (1'b0) $fell(reset) |-> state_reg.ctrl[REG_W-1:1] == 7'h00)
		else $error("control bits not cleared by reset");
	sequence ext_rise_s;
		$rose(state_reg.ext_s2);
	endsequence
	sequence port_change_s;
		state_reg.port_s2 != state_reg.port_d;
	endsequence
	sequence status_take_s;
		take & read & state_reg.rd_status;
	endsequence

	ext_flag_a: assert property (
		ext_rise_s ##1 1'b1 |-> state_reg.ctrl[BIT_EXIF])
		else $error("external flag not set on pin edge");
	ext_status_a: assert property (
		ext_rise_s ##1 1'b1 |-> state_reg.ist[EV_EXT])
		else $error("external status bit not set on pin edge");
	port_flag_a: assert property (
		port_change_s |=> state_reg.ctrl[BIT_PCIF] & state_reg.ist[EV_PORT])
		else $error("port change flag not set on pin change");
	tmr_flag_a: assert property (
		timer_zero_overflow |=> state_reg.ctrl[BIT_T0IF] & state_reg.ist[EV_TMR])
		else $error("timer flag not set on overflow");
	status_clear_a: assert property (
		status_take_s ##0 (state_reg.rdata[EV_TMR] & ~timer_zero_overflow) |=> ~state_reg.ist[EV_TMR])
		else $error("timer status bit not cleared by status read");
	flag_hold_a: assert property (
		(state_reg.ctrl[BIT_T0IF] & ~(take & write & address == ADDR_CTRL)) |=> state_reg.ctrl[BIT_T0IF])
		else $error("timer flag dropped without software clear");

	// ------------------------------------------------------------
	// checks: register access
	// ------------------------------------------------------------
	sequence req_first_s;
		(read | write) & ~state_reg.ack;
	endsequence
	sequence ctrl_read_s;
		read & ~state_reg.ack & (address == ADDR_CTRL);
	endsequence

	one_wait_a: assert property (
		req_first_s |-> waitrequest ##1 ~waitrequest)
		else $error("request not answered after one wait cycle");
	ctrl_read_a: assert property (
		ctrl_read_s |=> readdata[REG_W-1:0] == $past(state_reg.ctrl))
		else $error("control register read back wrong");
	unmapped_read_a: assert property (
		(read & ~state_reg.ack & (address != ADDR_CTRL) & (address != ADDR_IRQ_STATUS)
		& (address != ADDR_IRQ_MASK)) |=> readdata == '0)
		else $error("unmapped address read not zero");
	ctrl_write_a: assert property (
		(take & write & (address == ADDR_CTRL))
		|=> state_reg.ctrl[BIT_GLOBAL_EN:BIT_PCIE] == $past(writedata[BIT_GLOBAL_EN:BIT_PCIE]))
		else $error("control enable bits not written");
	mask_write_a: assert property (
		(take & write & (address == ADDR_IRQ_MASK)) |=> state_reg.imask == $past(writedata[EV_W-1:0]))
		else $error("mask register write lost");
endmodule : cic_core

// ==== testbench/cic_src_model.sv ====
// Purpose: event sources around the control register
// Assumes: same clock as the block
// Notes: pins idle low
`timescale 1ns/1ps
module cic_src_model
(
	input wire logic sys_clk,
	output logic tmr,
	output logic ext_pin,
	output logic [3:0] port,
	output logic [3:0] periph
);
	initial
	begin
		tmr = 1'b0;
		ext_pin = 1'b0;
		port = 4'h0;
		periph = 4'h0;
	end
	// one cycle overflow pulse
	task fire();
		@(posedge sys_clk);
		tmr <= 1'b1;
		@(posedge sys_clk);
		tmr <= 1'b0;
	endtask : fire
	// rising pin edge and port change
	task pins();
		@(posedge sys_clk);
		ext_pin <= 1'b1;
		port <= 4'h9;
		repeat (6) @(posedge sys_clk);
	endtask : pins
	// falling pin edge and port change back to idle
	task drop();
		@(posedge sys_clk);
		ext_pin <= 1'b0;
		port <= 4'h0;
		repeat (6) @(posedge sys_clk);
	endtask : drop
	// peripheral request levels
	task set_periph(input logic [3:0] v);
		periph <= v;
	endtask : set_periph
endmodule : cic_src_model

// ==== testbench/core_interrupt_control_register_tb_top.sv ====
// Purpose: bench for the control register
// Assumes: the slave inserts wait states; the master waits for them
// Notes: bit 0 loads PORT_FLAG_RESET (0 here) at reset; the reset checks mask it out
`timescale 1ns/1ps
module core_interrupt_control_register_tb_top;
	import cic_pkg::*;
	logic sys_clk = 1'b0, reset = 1'b1, read = 1'b0, write = 1'b0;
	logic [3:0] address = 4'h0;
	logic [31:0] writedata = 32'h0, readdata, q;
	logic waitrequest, core_irq_req, irq, tmr, ext_pin;
	logic [3:0] port, periph;
	int mismatches = 0, cmp_count = 0;
	cic_src_model SRC (.sys_clk(sys_clk), .tmr(tmr), .ext_pin(ext_pin), .port(port), .periph(periph));
	cic_core DUT (.sys_clk(sys_clk), .reset(reset), .address(address), .read(read), .write(write),
		.writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
		.timer_zero_overflow(tmr), .external_irq_pin(ext_pin), .upper_port_pins(port),
		.periph_irq_pending(periph), .core_irq_req(core_irq_req), .irq(irq));
	initial
	begin
		forever #2 sys_clk = ~sys_clk;
	end
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int waits;
		waits = 0;
		@(posedge sys_clk);
		address <= a;
		writedata <= d;
		write <= w;
		read <= ~w;
		@(posedge sys_clk);
		while (waitrequest !== 1'b0)
		begin
			waits++;
			@(posedge sys_clk);
		end
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		chk(waits, 1);
	endtask : bus
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task report_and_stop();
		$display("mismatches %0d compares %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : report_and_stop
	task events_test();
		bus(0, ADDR_CTRL, 0);
		chk(q & 32'hFE, 32'h0);
		SRC.fire();
		SRC.pins();
		bus(0, ADDR_CTRL, 0);
		chk(q, 32'h07);
		chk(core_irq_req, 1'b0);
		bus(0, ADDR_IRQ_STATUS, 0);
		chk(q, 32'h07);
		bus(1, ADDR_IRQ_MASK, 32'h07);
		@(negedge sys_clk);
		chk(irq, 1'b0);
		SRC.fire();
		@(negedge sys_clk);
		chk(irq, 1'b1);
		bus(0, ADDR_IRQ_STATUS, 0);
		chk(q, 32'h01);
		@(negedge sys_clk);
		chk(irq, 1'b0);
		bus(0, ADDR_CTRL, 0);
		chk(q, 32'h07);
		bus(0, 4'hC, 0);
		chk(q, 32'h0);
	endtask : events_test
	task enable_test();
		bus(1, ADDR_CTRL, 32'h00);
		bus(1, ADDR_CTRL, 32'h90);
		@(negedge sys_clk);
		chk(core_irq_req, 1'b0);
		SRC.drop();
		@(negedge sys_clk);
		chk(core_irq_req, 1'b0);
		SRC.pins();
		@(negedge sys_clk);
		chk(core_irq_req, 1'b1);
		chk(irq, 1'b1);
		bus(0, ADDR_CTRL, 0);
		chk(q, 32'h93);
		bus(0, ADDR_IRQ_STATUS, 0);
		chk(q, 32'h06);
		@(negedge sys_clk);
		chk(irq, 1'b0);
		bus(1, ADDR_CTRL, 32'h00);
		bus(1, ADDR_CTRL, 32'h88);
		@(negedge sys_clk);
		chk(core_irq_req, 1'b0);
		SRC.drop();
		@(negedge sys_clk);
		chk(core_irq_req, 1'b1);
	endtask : enable_test
	task reset_test();
		bus(1, ADDR_CTRL, 32'hFE);
		@(posedge sys_clk);
		reset <= 1'b1;
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		bus(0, ADDR_CTRL, 0);
		chk(q & 32'hFE, 32'h0);
		bus(0, ADDR_IRQ_MASK, 0);
		chk(q, 32'h0);
		@(negedge sys_clk);
		chk(core_irq_req, 1'b0);
		chk(irq, 1'b0);
	endtask : reset_test
	task gate_test();
		logic [7:0] c;
		logic e;
		for (int i = 0; i < 512; i++)
		begin
			c = i[7:0];
			SRC.set_periph({3'h0, i[8]});
			bus(1, ADDR_CTRL, {24'h0, c});
			e = c[7] & ((c[5] & c[2]) | (c[4] & c[1]) | (c[3] & c[0]) | (c[6] & i[8]));
			@(negedge sys_clk);
			chk(core_irq_req, e);
		end
	endtask : gate_test
	initial
	begin
		repeat (8) @(posedge sys_clk);
		reset <= 1'b0;
		events_test();
		enable_test();
		reset_test();
		gate_test();
		report_and_stop();
	end
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		mismatches++;
		report_and_stop();
	end
endmodule : core_interrupt_control_register_tb_top
